// file: rtl/pirp_fifo.sv
// Purpose: byte fifo between the rom reader and the parser
// Assumes: single clock, async active-low reset
// Notes: full and empty are exact; ready low while full
`timescale 1ns/1ps
`default_nettype none
module pirp_fifo #(
    parameter int width = pirp_pkg::pirp_fifo_width,
    parameter int depth = pirp_pkg::pirp_fifo_depth
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop, full, empty, next_in_ready;

    always_comb begin
        full = (wr_ptr[aw-1:0] == rd_ptr[aw-1:0]) &&
            (wr_ptr[aw] != rd_ptr[aw]);
        empty = (wr_ptr == rd_ptr);
        out_valid = !empty;
        out_data = mem[rd_ptr[aw-1:0]];
        push = in_valid && !full;
        pop = out_ready && !empty;
        next_wr_ptr = flush ? '0 : wr_ptr + (aw+1)'(push);
        next_rd_ptr = flush ? '0 : rd_ptr + (aw+1)'(pop);
        next_in_ready = (next_wr_ptr[aw-1:0] != next_rd_ptr[aw-1:0]) ||
            (next_wr_ptr[aw] == next_rd_ptr[aw]);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            in_ready <= next_in_ready;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[aw-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// file: rtl/pirp_parser.sv
// Purpose: walk and check the product info record of one rom image
// Assumes: rom bytes arrive in order from the record start via valid/ready
// Notes: start is a one-cycle pulse carrying the record pointer
// Functional notes
// - a record pointer of zero means no record, and nothing is parsed.
// - a tag with bit 7 clear is small: name in bits 6:3, length in 2:0.
// - a tag with bit 7 set is large, its name in the seven low bits.
// - a large item length follows as two bytes, low byte first.
// - small names 0x3, 0xE and 0xF are compat id, vendor and end tag.
// - large names 0x2, 0x4 and 0x10 are ident, vendor and wrapper.
// - keywords sit in wrappers and other items are reported and skipped.
// - the end tag closes the record and carries the checksum byte.
// - every record byte is summed and the sum must be zero.
// - a keyword field is two keyword bytes, a count, then the data.
`timescale 1ns/1ps
`default_nettype none
module pirp_parser (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [15:0] record_ptr,
    input wire logic rom_valid,
    output logic rom_ready,
    input wire logic [7:0] rom_data,
    output logic busy,
    output logic done,
    output logic csum_ok,
    output logic error,
    output logic no_record,
    output logic item_valid,
    output logic [2:0] item_kind,
    output logic [15:0] item_len,
    output logic kw_valid,
    output logic [15:0] kw_name,
    output logic [7:0] kw_len,
    output logic kw_data_valid,
    output logic [7:0] kw_data
);
    // ------------------------------------------------------------
    // input fifo
    // ------------------------------------------------------------
    pirp_stream_if fifo_out ();
    logic flush;
    logic take;

    pirp_fifo #(
        .width(pirp_pkg::pirp_fifo_width),
        .depth(pirp_pkg::pirp_fifo_depth)
    ) u_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .flush(flush),
        .in_valid(rom_valid),
        .in_ready(rom_ready),
        .in_data(rom_data),
        .out_valid(fifo_out.valid),
        .out_ready(fifo_out.ready),
        .out_data(fifo_out.data)
    );

    // ------------------------------------------------------------
    // item name decode
    // ------------------------------------------------------------
    function automatic pirp_pkg::pirp_item_t classify(input logic [7:0] t);
        pirp_pkg::pirp_item_t k;
        k = pirp_pkg::pirp_item_other;
        if (!t[pirp_pkg::pirp_tag_type_bit]) begin
            case (t[pirp_pkg::pirp_small_name_hi:pirp_pkg::pirp_small_name_lo])
                pirp_pkg::pirp_sn_compat_id: k = pirp_pkg::pirp_item_compat;
                pirp_pkg::pirp_sn_vendor: k = pirp_pkg::pirp_item_svendor;
                pirp_pkg::pirp_sn_end: k = pirp_pkg::pirp_item_end;
                default: k = pirp_pkg::pirp_item_other;
            endcase
        end else begin
            case (t[6:0])
                pirp_pkg::pirp_ln_ident: k = pirp_pkg::pirp_item_ident;
                pirp_pkg::pirp_ln_vendor: k = pirp_pkg::pirp_item_lvendor;
                pirp_pkg::pirp_ln_wrapper: k = pirp_pkg::pirp_item_wrapper;
                default: k = pirp_pkg::pirp_item_other;
            endcase
        end
        return k;
    endfunction

    // ------------------------------------------------------------
    // walker state
    // ------------------------------------------------------------
    pirp_pkg::pirp_state_t state, next_state;
    logic [16:0] count, next_count;
    logic [15:0] remain, next_remain;
    logic [7:0] sum, next_sum;
    logic [7:0] kw_left, next_kw_left;
    pirp_pkg::pirp_item_t kind, next_kind;
    logic next_busy, next_done, next_csum_ok, next_error, next_no_record;
    logic next_item_valid, next_kw_valid, next_kw_data_valid;
    logic [2:0] next_item_kind;
    logic [15:0] next_item_len, next_kw_name;
    logic [7:0] next_kw_len, next_kw_data;
    logic [7:0] b;
    logic [7:0] sum_b;

    assign fifo_out.ready = take;

    always_comb begin
        b = fifo_out.data;
        take = 1'b0;
        flush = 1'b0;
        next_state = state;
        next_count = count;
        next_remain = remain;
        next_sum = sum;
        next_kw_left = kw_left;
        next_kind = kind;
        next_busy = busy;
        next_done = 1'b0;
        next_csum_ok = csum_ok;
        next_error = error;
        next_no_record = no_record;
        next_item_valid = 1'b0;
        next_item_kind = item_kind;
        next_item_len = item_len;
        next_kw_valid = 1'b0;
        next_kw_name = kw_name;
        next_kw_len = kw_len;
        next_kw_data_valid = 1'b0;
        next_kw_data = kw_data;
        sum_b = sum + b;
        if (state != pirp_pkg::pirp_idle &&
            state != pirp_pkg::pirp_done) begin
            take = fifo_out.valid;
        end
        if (state != pirp_pkg::pirp_idle && take) begin
            next_sum = sum_b;
            next_count = count + 17'h0_0001;
        end
        case (state)
            pirp_pkg::pirp_idle: begin
                if (start) begin
                    flush = 1'b1;
                    next_count = '0;
                    next_sum = '0;
                    next_error = 1'b0;
                    next_csum_ok = 1'b0;
                    if (record_ptr == pirp_pkg::pirp_null_ptr) begin
                        next_no_record = 1'b1;
                        next_done = 1'b1;
                    end else begin
                        next_no_record = 1'b0;
                        next_busy = 1'b1;
                        next_state = pirp_pkg::pirp_tag;
                    end
                end
            end
            pirp_pkg::pirp_tag: begin
                if (take) begin
                    next_kind = classify(b);
                    next_item_kind = classify(b);
                    if (!b[pirp_pkg::pirp_tag_type_bit]) begin
                        next_remain = {13'h0000,
                            b[pirp_pkg::pirp_small_len_hi:0]};
                        next_item_len = next_remain;
                        next_item_valid = 1'b1;
                        if (classify(b) == pirp_pkg::pirp_item_end) begin
                            next_state = pirp_pkg::pirp_csum;
                        end else if (b[pirp_pkg::pirp_small_len_hi:0] ==
                            3'h0) begin
                            next_state = pirp_pkg::pirp_tag;
                        end else begin
                            next_state = pirp_pkg::pirp_skip;
                        end
                    end else begin
                        next_state = pirp_pkg::pirp_len_lo;
                    end
                end
            end
            pirp_pkg::pirp_len_lo: begin
                if (take) begin
                    next_remain = {8'h00, b};
                    next_state = pirp_pkg::pirp_len_hi;
                end
            end
            pirp_pkg::pirp_len_hi: begin
                if (take) begin
                    next_remain = {b, remain[7:0]};
                    next_item_len = {b, remain[7:0]};
                    next_item_valid = 1'b1;
                    if ({b, remain[7:0]} == 16'h0000) begin
                        next_state = pirp_pkg::pirp_tag;
                    end else if (kind == pirp_pkg::pirp_item_wrapper) begin
                        next_state = pirp_pkg::pirp_kw0;
                    end else begin
                        next_state = pirp_pkg::pirp_skip;
                    end
                end
            end
            pirp_pkg::pirp_skip: begin
                if (take) begin
                    next_remain = remain - 16'h0001;
                    if (remain == 16'h0001) begin
                        next_state = pirp_pkg::pirp_tag;
                    end
                end
            end
            pirp_pkg::pirp_kw0: begin
                if (take) begin
                    next_kw_name = {b, 8'h00};
                    next_remain = remain - 16'h0001;
                    next_state = (remain == 16'h0001) ?
                        pirp_pkg::pirp_tag : pirp_pkg::pirp_kw1;
                end
            end
            pirp_pkg::pirp_kw1: begin
                if (take) begin
                    next_kw_name = {kw_name[15:8], b};
                    next_remain = remain - 16'h0001;
                    next_state = (remain == 16'h0001) ?
                        pirp_pkg::pirp_tag : pirp_pkg::pirp_kw_len;
                end
            end
            pirp_pkg::pirp_kw_len: begin
                if (take) begin
                    next_kw_len = b;
                    next_kw_left = b;
                    next_kw_valid = 1'b1;
                    next_remain = remain - 16'h0001;
                    if (remain == 16'h0001) begin
                        next_state = pirp_pkg::pirp_tag;
                    end else if (b == 8'h00) begin
                        next_state = pirp_pkg::pirp_kw0;
                    end else begin
                        next_state = pirp_pkg::pirp_kw_data;
                    end
                end
            end
            pirp_pkg::pirp_kw_data: begin
                if (take) begin
                    next_kw_data = b;
                    next_kw_data_valid = 1'b1;
                    next_kw_left = kw_left - 8'h01;
                    next_remain = remain - 16'h0001;
                    if (remain == 16'h0001) begin
                        next_state = pirp_pkg::pirp_tag;
                    end else if (kw_left == 8'h01) begin
                        next_state = pirp_pkg::pirp_kw0;
                    end
                end
            end
            pirp_pkg::pirp_csum: begin
                if (take) begin
                    next_remain = remain - 16'h0001;
                    if (remain <= 16'h0001) begin
                        next_csum_ok = (sum_b == 8'h00);
                        next_error = (sum_b != 8'h00);
                        next_busy = 1'b0;
                        next_done = 1'b1;
                        next_state = pirp_pkg::pirp_done;
                    end
                end
            end
            pirp_pkg::pirp_done: begin
                next_state = pirp_pkg::pirp_idle;
            end
            default: begin
                next_state = pirp_pkg::pirp_idle;
            end
        endcase
        if (state != pirp_pkg::pirp_idle &&
            state != pirp_pkg::pirp_done &&
            next_state != pirp_pkg::pirp_done &&
            next_count >= pirp_pkg::pirp_search_limit) begin
            next_error = 1'b1;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = pirp_pkg::pirp_done;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= pirp_pkg::pirp_idle;
            count <= '0;
            remain <= '0;
            sum <= '0;
            kw_left <= '0;
            kind <= pirp_pkg::pirp_item_other;
            busy <= 1'b0;
            done <= 1'b0;
            csum_ok <= 1'b0;
            error <= 1'b0;
            no_record <= 1'b0;
            item_valid <= 1'b0;
            item_kind <= '0;
            item_len <= '0;
            kw_valid <= 1'b0;
            kw_name <= '0;
            kw_len <= '0;
            kw_data_valid <= 1'b0;
            kw_data <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            remain <= next_remain;
            sum <= next_sum;
            kw_left <= next_kw_left;
            kind <= next_kind;
            busy <= next_busy;
            done <= next_done;
            csum_ok <= next_csum_ok;
            error <= next_error;
            no_record <= next_no_record;
            item_valid <= next_item_valid;
            item_kind <= next_item_kind;
            item_len <= next_item_len;
            kw_valid <= next_kw_valid;
            kw_name <= next_kw_name;
            kw_len <= next_kw_len;
            kw_data_valid <= next_kw_data_valid;
            kw_data <= next_kw_data;
        end
    end
endmodule
`default_nettype wire

// file: rtl/pirp_pkg.sv
// Purpose: shared constants and types of the product info record parser
// Assumes: byte-wide record stream read from an expansion ROM image
// Notes: offsets are byte offsets within one ROM image
package pirp_pkg;
    // ------------------------------------------------------------
    // record limits
    // ------------------------------------------------------------
    localparam logic [16:0] pirp_search_limit = 17'h1_0000;
    localparam logic [15:0] pirp_null_ptr = 16'h0000;
    localparam int pirp_fifo_depth = 32;
    localparam int pirp_fifo_width = 8;

    // ------------------------------------------------------------
    // tag fields
    // ------------------------------------------------------------
    localparam int pirp_tag_type_bit = 7;
    localparam int pirp_small_name_hi = 6;
    localparam int pirp_small_name_lo = 3;
    localparam int pirp_small_len_hi = 2;

    // ------------------------------------------------------------
    // item names
    // ------------------------------------------------------------
    localparam logic [3:0] pirp_sn_compat_id = 4'h3;
    localparam logic [3:0] pirp_sn_vendor = 4'hE;
    localparam logic [3:0] pirp_sn_end = 4'hF;
    localparam logic [6:0] pirp_ln_ident = 7'h02;
    localparam logic [6:0] pirp_ln_vendor = 7'h04;
    localparam logic [6:0] pirp_ln_wrapper = 7'h10;

    // ------------------------------------------------------------
    // item class reported with each item
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        pirp_item_other = 3'b000,
        pirp_item_compat = 3'b001,
        pirp_item_svendor = 3'b010,
        pirp_item_end = 3'b011,
        pirp_item_ident = 3'b100,
        pirp_item_lvendor = 3'b101,
        pirp_item_wrapper = 3'b110
    } pirp_item_t;

    typedef enum logic [3:0] {
        pirp_idle = 4'b0000,
        pirp_tag = 4'b0001,
        pirp_len_lo = 4'b0010,
        pirp_len_hi = 4'b0011,
        pirp_skip = 4'b0100,
        pirp_kw0 = 4'b0101,
        pirp_kw1 = 4'b0110,
        pirp_kw_len = 4'b0111,
        pirp_kw_data = 4'b1000,
        pirp_csum = 4'b1001,
        pirp_done = 4'b1010
    } pirp_state_t;
endpackage

// file: rtl/pirp_stream_if.sv
// Purpose: valid/ready byte stream between parser and its fifo
// Assumes: single clock
// Notes: source drives valid and data, sink drives ready
`timescale 1ns/1ps
`default_nettype none
interface pirp_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: sim/pirp_parser_sva.sv
// Purpose: port checks for the product info record parser
// Assumes: single clock, asynchronous active-low reset
// Notes: bound to every parser instance below
`timescale 1ns/1ps
`default_nettype none
module pirp_parser_sva (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [15:0] record_ptr,
    input wire logic busy,
    input wire logic done,
    input wire logic csum_ok,
    input wire logic error,
    input wire logic no_record,
    input wire logic item_valid,
    input wire logic [2:0] item_kind,
    input wire logic [15:0] item_len,
    input wire logic kw_valid,
    input wire logic kw_data_valid
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    logic idle;
    assign idle = !busy && !done;

    chk_null_ptr: assert property (
        start && idle && record_ptr == 16'h0000 |=> done && no_record && !busy)
        else $error("null pointer parse did not end at once");
    chk_done_pulse: assert property (
        done |=> !done && !busy)
        else $error("done longer than one cycle");
    chk_flag_hold: assert property (
        idle && !start |=> $stable({csum_ok, error, no_record}))
        else $error("result flags moved while idle");
    chk_small_len: assert property (
        item_valid && item_kind inside {3'h1, 3'h2, 3'h3}
        |-> item_len <= 16'h0007)
        else $error("small item length above seven");
    chk_end_close: assert property (
        item_valid && item_kind == pirp_pkg::pirp_item_end |-> ##[1:16] done)
        else $error("end item did not close the record");
    chk_kw_inside: assert property (
        kw_valid || kw_data_valid |-> busy && !done)
        else $error("keyword output outside a parse");
    chk_err_done: assert property (
        $rose(error) |-> done && !csum_ok)
        else $error("error raised away from done");
    chk_ok_done: assert property (
        $rose(csum_ok) |-> done && !error && !no_record)
        else $error("checksum good raised away from done");

    cov_good: cover property (done && csum_ok);
    cov_bad: cover property (done && error);
    cov_kw: cover property (kw_data_valid);
endmodule

bind pirp_parser pirp_parser_sva chk_u (
    .clock(clock), .arst_n(arst_n), .start(start), .record_ptr(record_ptr),
    .busy(busy), .done(done), .csum_ok(csum_ok), .error(error),
    .no_record(no_record), .item_valid(item_valid), .item_kind(item_kind),
    .item_len(item_len), .kw_valid(kw_valid), .kw_data_valid(kw_data_valid));
`default_nettype wire

// file: sim/pirp_parser_tb_top.sv
// Purpose: self-checking bench for the record parser
// Assumes: rom model behind the byte stream, bench drives on falling edge
// Notes: the 64 KB limit run dominates the run time
`timescale 1ns/1ps
`default_nettype none
module pirp_parser_tb_top;
    logic clock, arst_n, start, go, stall;
    logic [15:0] record_ptr;
    logic rom_valid, rom_ready, busy, done, csum_ok, error, no_record;
    logic [7:0] rom_data, kw_len, kw_data, sum;
    logic item_valid, kw_valid, kw_data_valid;
    logic [2:0] item_kind;
    logic [15:0] item_len, kw_name;
    logic [31:0] got_item[$], exp_item[$], got_kw[$], exp_kw[$];
    logic [31:0] got_dat[$], exp_dat[$];
    int err_total;
    int cmp_count;

    pirp_parser dut_u (.clock(clock), .arst_n(arst_n), .start(start),
        .record_ptr(record_ptr), .rom_valid(rom_valid),
        .rom_ready(rom_ready), .rom_data(rom_data), .busy(busy),
        .done(done), .csum_ok(csum_ok), .error(error),
        .no_record(no_record), .item_valid(item_valid),
        .item_kind(item_kind), .item_len(item_len), .kw_valid(kw_valid),
        .kw_name(kw_name), .kw_len(kw_len), .kw_data_valid(kw_data_valid),
        .kw_data(kw_data));
    pirp_rom_model rom_u (.clock(clock), .arst_n(arst_n), .go(go),
        .stall(stall), .rom_ready(rom_ready), .rom_valid(rom_valid),
        .rom_data(rom_data));

    always #20 clock = ~clock;

    always @(negedge clock) begin
        if (item_valid === 1'b1)
            got_item.push_back({13'h0000, item_kind, item_len});
        if (kw_valid === 1'b1)
            got_kw.push_back({8'h00, kw_name, kw_len});
        if (kw_data_valid === 1'b1)
            got_dat.push_back({24'h00_0000, kw_data});
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic put(input logic [7:0] b);
        rom_u.mem[rom_u.len] = b;
        rom_u.len++;
        sum = sum + b;
    endtask

    task automatic expi(input logic [2:0] kind, input logic [15:0] n);
        exp_item.push_back({13'h0000, kind, n});
    endtask

    task automatic clear_image();
        rom_u.len = 0;
        sum = 8'h00;
        exp_item.delete();
        exp_kw.delete();
        exp_dat.delete();
    endtask

    task automatic close_record(input logic [7:0] bad);
        put(8'h79);
        put(8'h00 - sum + bad);
        expi(3'h3, 16'h0001);
    endtask

    task automatic build_walk(input logic [7:0] bad);
        logic [7:0] img [18] = '{8'h82, 8'h03, 8'h00, 8'h41, 8'h42, 8'h43,
            8'h90, 8'h09, 8'h00, 8'h50, 8'h4e, 8'h02, 8'h31, 8'h32,
            8'h53, 8'h4e, 8'h01, 8'h37};
        clear_image();
        foreach (img[i]) put(img[i]);
        expi(3'h4, 16'h0003);
        expi(3'h6, 16'h0009);
        exp_kw = '{32'h0050_4e02, 32'h0053_4e01};
        exp_dat = '{32'h0000_0031, 32'h0000_0032, 32'h0000_0037};
        close_record(bad);
    endtask

    task automatic run_parse(input logic [15:0] ptr, input bit slow,
                             input int total);
        int n = 0;
        got_item.delete();
        got_kw.delete();
        got_dat.delete();
        rom_u.total = total;
        @(negedge clock);
        start = 1'b1;
        record_ptr = ptr;
        go = (ptr != 16'h0000);
        stall = slow;
        @(negedge clock);
        start = 1'b0;
        go = 1'b0;
        while (done !== 1'b1 && n < 70000) begin
            @(negedge clock);
            n++;
        end
        check("done", 32'(done), 32'h0000_0001);
        @(negedge clock);
    endtask

    task automatic compare_all();
        check("items", got_item.size(), exp_item.size());
        check("keywords", got_kw.size(), exp_kw.size());
        check("kw bytes", got_dat.size(), exp_dat.size());
        foreach (exp_item[i])
            if (i < got_item.size())
                check("item", got_item[i], exp_item[i]);
        foreach (exp_kw[i])
            if (i < got_kw.size())
                check("keyword", got_kw[i], exp_kw[i]);
        foreach (exp_dat[i])
            if (i < got_dat.size())
                check("kw byte", got_dat[i], exp_dat[i]);
    endtask

    task automatic flags(input logic ok, input logic bad, input logic none);
        check("csum_ok", 32'(csum_ok), 32'(ok));
        check("error", 32'(error), 32'(bad));
        check("no_record", 32'(no_record), 32'(none));
    endtask

    task automatic t_none();
        clear_image();
        run_parse(16'h0000, 1'b0, 0);
        compare_all();
        flags(1'b0, 1'b0, 1'b1);
    endtask

    task automatic t_bad_sum();
        build_walk(8'h01);
        run_parse(16'h0040, 1'b0, rom_u.len);
        compare_all();
        flags(1'b0, 1'b1, 1'b0);
    endtask

    // the walk follows a failed sum, so a stale total would show
    task automatic t_walk();
        build_walk(8'h00);
        run_parse(16'h0040, 1'b1, rom_u.len);
        compare_all();
        flags(1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_kinds();
        logic [7:0] img [14] = '{8'h1a, 8'h01, 8'h02, 8'h71, 8'h03, 8'h84,
            8'h01, 8'h00, 8'h04, 8'h09, 8'h05, 8'h85, 8'h00, 8'h00};
        clear_image();
        foreach (img[i]) put(img[i]);
        exp_item = '{32'h0001_0002, 32'h0002_0001, 32'h0005_0001,
                     32'h0000_0001, 32'h0000_0000};
        close_record(8'h00);
        run_parse(16'h0100, 1'b0, rom_u.len);
        compare_all();
        flags(1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_reset_mid();
        build_walk(8'h00);
        rom_u.total = rom_u.len;
        start = 1'b1;
        record_ptr = 16'h0040;
        go = 1'b1;
        @(negedge clock);
        start = 1'b0;
        go = 1'b0;
        repeat (5) @(negedge clock);
        arst_n = 1'b0;
        #1;
        check("busy in reset", 32'(busy), 32'h0000_0000);
        check("ready in reset", 32'(rom_ready), 32'h0000_0001);
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        run_parse(16'h0040, 1'b1, rom_u.len);
        compare_all();
        flags(1'b1, 1'b0, 1'b0);
    endtask

    // large item running past 64 KB with no end tag
    task automatic t_limit();
        clear_image();
        put(8'h84);
        put(8'hff);
        put(8'hff);
        expi(3'h5, 16'hffff);
        run_parse(16'h0200, 1'b0, 65536);
        compare_all();
        flags(1'b0, 1'b1, 1'b0);
    endtask

    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        start = 1'b0;
        go = 1'b0;
        stall = 1'b0;
        record_ptr = 16'h0000;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        t_none();
        t_bad_sum();
        t_walk();
        t_kinds();
        t_reset_mid();
        t_limit();
        stop_test();
    end

    initial begin
        repeat (90000) @(posedge clock);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire

// file: sim/pirp_rom_model.sv
// Purpose: expansion rom stand-in streaming one record image
// Assumes: byte taken on a rising edge with valid and ready high
// Notes: drives on falling edges; data line scrambled when idle
`timescale 1ns/1ps
`default_nettype none
module pirp_rom_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic go,
    input wire logic stall,
    input wire logic rom_ready,
    output logic rom_valid,
    output logic [7:0] rom_data
);
    logic [7:0] mem [0:255];
    int len;
    int total;
    int idx;
    int tick;
    bit active;
    bit took_q;
    bit go_q;

    // bytes past the loaded image read as zero fill
    function automatic logic [7:0] rom_at(input int i);
        return (i < len) ? mem[i] : 8'h00;
    endfunction

    always @(posedge clock) begin
        took_q <= rom_valid && rom_ready;
        go_q <= go;
    end

    always @(negedge clock or negedge arst_n) begin
        tick++;
        if (!arst_n) begin
            active = 1'b0;
            rom_valid = 1'b0;
            rom_data = 8'ha5;
        end else begin
            if (go_q) begin
                active = 1'b1;
                idx = 0;
            end else if (took_q) begin
                idx++;
            end
            if (idx >= total || idx >= 65536)
                active = 1'b0;
            // an offer stands until the parser side takes it
            if (!rom_valid || took_q || go_q) begin
                if (active && (!stall || tick % 3 != 0)) begin
                    rom_valid = 1'b1;
                    rom_data = rom_at(idx);
                end else begin
                    rom_valid = 1'b0;
                    rom_data = ~rom_data;
                end
            end
        end
    end
endmodule
`default_nettype wire
